// >>> common/rstack_regs.svh
`ifndef RSTACK_REGS_SVH
`define RSTACK_REGS_SVH

// widths of the return stack datapath
`define RSC_PC_W         21
`define RSC_SP_W         5
`define RSC_ADDR_W       8
`define RSC_IRQ_W        2

// stack pointer landmarks
`define RSC_SP_EMPTY     5'h00
`define RSC_SP_FIRST     5'h01
`define RSC_SP_PRE_FULL  5'h1E
`define RSC_SP_MAX       5'h1F
`define RSC_SP_STEP      5'h01
`define RSC_PC_STEP2     21'h000002
`define RSC_PC_ZERO      21'h000000

// register byte offsets
`define RSC_OFF_CTRL     8'h00
`define RSC_OFF_TOP_LO   8'h04
`define RSC_OFF_TOP_HI   8'h08
`define RSC_OFF_TOP_UP   8'h0C
`define RSC_OFF_CFG      8'h10
`define RSC_OFF_IRQ_STS  8'h14
`define RSC_OFF_IRQ_MSK  8'h18

// control register fields
`define RSC_CTRL_OVF_BIT 7
`define RSC_CTRL_UNF_BIT 6
`define RSC_CTRL_SP_MSB  4
`define RSC_CTRL_SP_LSB  0

// configuration, interrupt fields and reset values
`define RSC_CFG_ORE_BIT  0
`define RSC_CFG_ORE_RST  1'h1
`define RSC_IRQ_OVF_BIT  0
`define RSC_IRQ_UNF_BIT  1
`define RSC_IRQ_RST      2'h0

// byte lanes of the top entry
`define RSC_LANE_LO      2'h0
`define RSC_LANE_HI      2'h1
`define RSC_LANE_UP      2'h2

// bit ranges of the byte lanes within an entry
`define RSC_LO_MSB       7
`define RSC_LO_LSB       0
`define RSC_HI_MSB       15
`define RSC_HI_LSB       8
`define RSC_UP_MSB       20
`define RSC_UP_LSB       16
`define RSC_UP_W         5
`define RSC_UP_PAD       3'h0

// ahb encodings
`define RSC_HTRANS_ACT   1
`define RSC_WORD_ZERO    32'h00000000
`define RSC_BYTE_ZERO    8'h00

`endif

// >>> common/rstack_pkg.sv
`default_nettype none
package rstack_pkg;

    // request from the processor core, one operation per cycle
    typedef struct packed {
        logic        call;      // call: push the return address
        logic        push;      // explicit push: push the current pc
        logic        ret;       // return: pop and deliver the address
        logic        pop;       // explicit pop: discard the top entry
        logic [20:0] ret_addr;  // return address pushed by a call
        logic [20:0] pc;        // current program counter
    } core_req_s;

    // answer to the processor core
    typedef struct packed {
        logic        valid;     // one-cycle pulse after a return
        logic        underflow; // the return hit an empty stack
        logic [20:0] addr;      // address loaded into the pc
    } core_resp_s;

    // bus data phase tracking
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_RDWAIT,
        PH_RDDONE
    } bus_phase_e;

endpackage
`default_nettype wire

// >>> hdl/return_stack_pointer_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "rstack_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - five-bit pointer in control bits 4..0
// - push increments then stores; pop reads then decrements
// - reset leaves the pointer at zero
// - software reads and writes the pointer field
// - thirty-one pushes raise the overflow flag
// - reset-enabled overflow stores pc+2, resets, pointer zero
// - saturating overflow holds pointer 31, entry unchanged
// - empty pop returns zero, sets underflow, pointer zero
// - underflow only redirects to zero, no reset
// - flags stay until software or power-on clears
// - push instruction stores current pc as top
// - pop instruction only decrements the pointer
// - top entry bytes readable and writable by software
// - control bit 5 always reads zero
// - flag reads one once the event happened
module return_stack_pointer_control
    import rstack_pkg::*;
(
    // clock and power-on reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic [31:0]                  hrdata,
    output logic                         hresp,
    // processor core
    input  wire rstack_pkg::core_req_s   core_req,
    output rstack_pkg::core_resp_s       core_resp,
    // system
    output logic                         device_reset_req,
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    // the entry array has no reset; a slot that software makes the top by a
    // pointer write before any push shows whatever the array held at power-up,
    // so a supervisor relocating the level should fill the slots it exposes

    bus_phase_e                ph_q;          // data phase in progress
    bus_phase_e                ph_d;
    logic [`RSC_ADDR_W-1:0]    addr_q;        // address of the data phase
    logic [31:0]               hrdata_q;      // registered read data
    logic [`RSC_SP_W-1:0]      sp_q;          // stack level
    logic [`RSC_SP_W-1:0]      sp_d;
    logic                      ovf_q;         // full or overflow flag
    logic                      unf_q;         // underflow flag
    logic                      ore_q;         // overflow reset enable
    logic [`RSC_IRQ_W-1:0]     irq_sts_q;     // sticky event bits
    logic [`RSC_IRQ_W-1:0]     irq_msk_q;     // event enables
    logic [`RSC_IRQ_W-1:0]     irq_ev;        // events of this cycle
    core_resp_s                resp_q;        // answer to the core
    logic                      dev_rst_q;     // device reset pulse
    logic [`RSC_PC_W-1:0]      mem [1:31];    // return entries

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // replace one byte lane of an entry, upper lane keeps only its low bits
    function automatic logic [`RSC_PC_W-1:0] set_lane(
        input logic [`RSC_PC_W-1:0] old,
        input logic [1:0]           lane,
        input logic [7:0]           val
    );
        logic [`RSC_PC_W-1:0] res;
        res = old;
        case (lane)
            `RSC_LANE_LO: res[`RSC_LO_MSB:`RSC_LO_LSB] = val;
            `RSC_LANE_HI: res[`RSC_HI_MSB:`RSC_HI_LSB] = val;
            // the upper lane is narrower, its spare write bits are dropped
            `RSC_LANE_UP: res[`RSC_UP_MSB:`RSC_UP_LSB] = val[`RSC_UP_W-1:0];
            default:      res        = old;
        endcase
        return res;
    endfunction

    // widen a byte-sized field to a read word
    function automatic logic [31:0] to_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // a transfer is taken only while the bus is ready; its address is kept
    // for the data phase, where write data land or the read is captured
    wire accept      = hsel & hready & htrans[`RSC_HTRANS_ACT];
    wire wr_phase    = (ph_q == PH_WRITE);
    wire rd_capture  = (ph_q == PH_RDWAIT);
    // register selects from the latched address
    wire sel_ctrl    = (addr_q == `RSC_OFF_CTRL);
    wire sel_top_lo  = (addr_q == `RSC_OFF_TOP_LO);
    wire sel_top_hi  = (addr_q == `RSC_OFF_TOP_HI);
    wire sel_top_up  = (addr_q == `RSC_OFF_TOP_UP);
    wire sel_cfg     = (addr_q == `RSC_OFF_CFG);
    wire sel_sts     = (addr_q == `RSC_OFF_IRQ_STS);
    wire sel_msk     = (addr_q == `RSC_OFF_IRQ_MSK);
    // write strobes exist only in the data phase of a write
    wire sel_top     = sel_top_lo | sel_top_hi | sel_top_up;
    wire wr_ctrl     = wr_phase & sel_ctrl;
    wire wr_top      = wr_phase & sel_top;
    wire wr_cfg      = wr_phase & sel_cfg;
    wire wr_msk      = wr_phase & sel_msk;
    wire rd_sts      = rd_capture & sel_sts;

    // byte lane picked by the top entry register addressed
    wire [1:0] top_lane = sel_top_up ? `RSC_LANE_UP :
                          sel_top_hi ? `RSC_LANE_HI : `RSC_LANE_LO;

    // reads stall one cycle so a write just before is already visible
    assign hreadyout = (ph_q != PH_RDWAIT);
    // no error response: unmapped offsets read zero and ignore writes
    assign hresp     = 1'h0;
    assign hrdata    = hrdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // core operation decode

    // a push wins when the core raises a push and a pop in one cycle;
    // a return is a pop that also answers with the popped address
    wire is_push   = core_req.call | core_req.push;
    wire is_ret    = ~is_push & core_req.ret;
    wire is_pop    = ~is_push & (core_req.ret | core_req.pop);
    // pointer landmarks: empty, one below full, and saturated
    wire sp_empty  = (sp_q == `RSC_SP_EMPTY);
    wire sp_pre    = (sp_q == `RSC_SP_PRE_FULL);
    wire sp_max    = (sp_q == `RSC_SP_MAX);

    // a call pushes its return address, a push instruction the current pc
    wire [`RSC_PC_W-1:0] push_val = core_req.call ? core_req.ret_addr
                                                  : core_req.pc;

    // 31st push or any push beyond it marks the stack full
    wire ovf_event = is_push & (sp_pre | sp_max);
    // the 31st push under reset enable stores pc+2 and resets
    wire ovf_reset = is_push & sp_pre & ore_q;
    // a pop on an empty stack underflows
    wire unf_event = is_pop & sp_empty;

    // pointer after a push, computed first so the store lands above
    wire [`RSC_SP_W-1:0] sp_inc = sp_q + `RSC_SP_STEP;
    wire [`RSC_SP_W-1:0] sp_dec = sp_q - `RSC_SP_STEP;

    // entry store: never once the stack is saturated at 31
    wire mem_core_we = is_push & ~sp_max;
    wire [`RSC_PC_W-1:0] mem_core_val = ovf_reset ? core_req.pc + `RSC_PC_STEP2
                                                  : push_val;

    // software top entry write only lands on an occupied slot
    // a core push that stores an entry in the same cycle wins and the software byte is lost
    wire mem_sw_we = wr_top & ~sp_empty & ~mem_core_we;

    // top of stack, zero when empty
    wire [`RSC_PC_W-1:0] top_val = sp_empty ? `RSC_PC_ZERO : mem[sp_q];

    ////////////////////////////////////////////////////////////////////////////
    // pointer next value

    // core operations win over a software pointer write in the same cycle;
    // the flag bits of that write still take effect
    always_comb begin
        sp_d = sp_q;
        if (is_push) begin
            if (ovf_reset) begin
                // device reset leaves the pointer at zero
                sp_d = `RSC_SP_EMPTY;
            end else if (sp_max) begin
                // saturated: pointer stays at 31
                sp_d = `RSC_SP_MAX;
            end else begin
                // increment before the store
                sp_d = sp_inc;
            end
        end else if (is_pop) begin
            if (sp_empty) begin
                // empty pop holds the pointer at zero
                sp_d = `RSC_SP_EMPTY;
            end else begin
                // return and pop instruction both drop one level
                sp_d = sp_dec;
            end
        end else if (wr_ctrl) begin
            // supervisor relocates the stack level
            sp_d = hwdata[`RSC_CTRL_SP_MSB:`RSC_CTRL_SP_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus phase next value

    // reads stall one cycle, writes none; no transfer is taken while a read
    // is stalled because hready is then low
    always_comb begin
        ph_d = PH_IDLE;
        if (ph_q == PH_RDWAIT) begin
            // finish the stalled read
            ph_d = PH_RDDONE;
        end else if (accept) begin
            // start a data phase
            ph_d = hwrite ? PH_WRITE : PH_RDWAIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus phase and address

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // bus idle and ready out of reset
            ph_q   <= PH_IDLE;
            addr_q <= `RSC_OFF_CTRL;
        end else begin
            ph_q <= ph_d;
            if (accept) begin
                // only the low address byte selects a register
                addr_q <= haddr[`RSC_ADDR_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data mux

    // bit 5 of the control register is unimplemented and reads zero
    wire [7:0] ctrl_rd = {ovf_q, unf_q, 1'h0, sp_q};

    // upper bits of every register and every unmapped offset read zero
    wire [31:0] rd_word =
        sel_ctrl   ? to_word(ctrl_rd) :
        sel_top_lo ? to_word(top_val[`RSC_LO_MSB:`RSC_LO_LSB]) :
        sel_top_hi ? to_word(top_val[`RSC_HI_MSB:`RSC_HI_LSB]) :
        sel_top_up ? to_word({`RSC_UP_PAD, top_val[`RSC_UP_MSB:`RSC_UP_LSB]}) :
        sel_cfg    ? {31'h00000000, ore_q} :
        sel_sts    ? {30'h00000000, irq_sts_q} :
        sel_msk    ? {30'h00000000, irq_msk_q} :
                     `RSC_WORD_ZERO;

    // capture read data in the stall cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= `RSC_WORD_ZERO;
        end else if (rd_capture) begin
            // stands on the bus until the next read is captured
            hrdata_q <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stack pointer

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= `RSC_SP_EMPTY;
        end else begin
            // five bits hold every level from 0 to 31
            sp_q <= sp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags: set wins over a software clear in the same cycle

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // only the power-on reset clears the flags in hardware
            ovf_q <= 1'h0;
            unf_q <= 1'h0;
        end else begin
            // writing zero clears, writing one never sets
            if (ovf_event) begin
                // also set by the reset-enabled overflow, which keeps it
                ovf_q <= 1'h1;
            end else if (wr_ctrl && !hwdata[`RSC_CTRL_OVF_BIT]) begin
                ovf_q <= 1'h0;
            end
            if (unf_event) begin
                unf_q <= 1'h1;
            end else if (wr_ctrl && !hwdata[`RSC_CTRL_UNF_BIT]) begin
                unf_q <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // reset value picks the device reset on overflow
            ore_q <= `RSC_CFG_ORE_RST;
        end else if (wr_cfg) begin
            ore_q <= hwdata[`RSC_CFG_ORE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return entries, one write per cycle

    // no reset: the pointer alone says which slots are live
    always_ff @(posedge hclk) begin
        if (mem_core_we) begin
            // store at the incremented level
            mem[sp_inc] <= mem_core_val;
        end else if (mem_sw_we) begin
            // software rewrites one byte of the top entry
            mem[sp_q] <= set_lane(mem[sp_q], top_lane, hwdata[`RSC_LO_MSB:`RSC_LO_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer to the core and device reset request

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_q    <= '0;
            dev_rst_q <= 1'h0;
        end else begin
            // registered answer: the core sees it one cycle after the return
            resp_q.valid     <= is_ret;
            // an underflow redirects to zero and never asks for a reset
            resp_q.underflow <= is_ret & sp_empty;
            // read before decrement; empty delivers address zero
            if (is_ret) begin
                resp_q.addr <= top_val;
            end
            // only the reset-enabled overflow asks for a device reset; the
            // block itself keeps its flags and settings but drops its pointer to zero; only hresetn clears the rest
            dev_rst_q <= ovf_reset;
        end
    end

    assign core_resp        = resp_q;
    assign device_reset_req = dev_rst_q;

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, cleared by reading the status register

    // the status register keeps the bit order of the mask register
    assign irq_ev[`RSC_IRQ_OVF_BIT] = ovf_event;
    assign irq_ev[`RSC_IRQ_UNF_BIT] = unf_event;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_sts_q <= `RSC_IRQ_RST;
            irq_msk_q <= `RSC_IRQ_RST;
        end else begin
            // a new event survives the clearing read
            irq_sts_q <= (rd_sts ? `RSC_IRQ_RST : irq_sts_q) | irq_ev;
            // mask register reads back as written
            if (wr_msk) begin
                irq_msk_q <= hwdata[`RSC_IRQ_W-1:0];
            end
        end
    end

    // level interrupt while any unmasked event is pending
    assign irq = |(irq_sts_q & irq_msk_q);

endmodule
`default_nettype wire

// >>> sim/rstack_core_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// processor core issuing calls, returns, pushes and pops
module rstack_core_model
    import rstack_pkg::*;
(
    // clock
    input  wire logic              hclk,
    // core link
    output var rstack_pkg::core_req_s  core_req,
    input  wire rstack_pkg::core_resp_s core_resp
);
    import rstack_pkg::*;

    // idle until the first operation
    initial core_req = '0;

    // one operation, k = {call, push, ret, pop}, held for one edge only
    task automatic op(input logic [3:0] k, input logic [20:0] v, output core_resp_s r);
        @(posedge hclk);
        core_req <= {k, v, v};
        @(posedge hclk);
        // released address lines show the inverse, never the stale value
        core_req <= {4'h0, ~v, ~v};
        #1 r = core_resp;
    endtask
endmodule
`default_nettype wire

// >>> sim/rstack_chk.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// port-level checker for the return stack block
module rstack_chk
    import rstack_pkg::*;
(
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // bus handshake
    input  wire logic                   hsel,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic                   hready,
    input  wire logic                   hreadyout,
    input  wire logic                   hresp,
    // core link and system
    input  wire rstack_pkg::core_req_s  core_req,
    input  wire rstack_pkg::core_resp_s core_resp,
    input  wire logic                   device_reset_req
);
    import rstack_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // decoded request classes
    wire take     = hsel && hready && htrans[1];
    wire psh      = core_req.call || core_req.push;
    wire ret_only = core_req.ret && !psh;

    a_okay_resp: assert property (hresp == 1'h0)
        else $error("slave response not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_ret_answer: assert property (ret_only |=> core_resp.valid)
        else $error("return not answered");
    a_valid_cause: assert property (core_resp.valid |-> $past(ret_only))
        else $error("answer without return");
    a_unf_zero: assert property (core_resp.underflow |-> core_resp.valid && core_resp.addr == 21'h000000)
        else $error("underflow address not zero");
    a_rst_pulse: assert property (device_reset_req |=> !device_reset_req)
        else $error("device reset pulse too long");
    a_rst_cause: assert property (device_reset_req |-> $past(psh))
        else $error("device reset without push");
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rstack_regs.svh"

// compare and count
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

////////////////////////////////////////////////////////////////////////////////
module tb;
    import rstack_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, device_reset_req, irq;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [20:0] pcv;
    core_req_s   core_req;
    core_resp_s  core_resp, r;
    int          errors = 0, total_checks = 0, cyc = 0;

    // clock generation
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end

    return_stack_pointer_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .core_req(core_req), .core_resp(core_resp), .device_reset_req(device_reset_req),
        .irq(irq));
    rstack_core_model u_core (.hclk(hclk), .core_req(core_req), .core_resp(core_resp));

    ////////////////////////////////////////////////////////////////////////////
    // one single-word bus transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                        output logic [31:0] q);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'h1, a, v, d);
    endtask
    // read and compare
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h00000000, d);
        `CHK(d, e)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rc(`RSC_OFF_CTRL, 32'h00000000);
        rc(`RSC_OFF_CFG, 32'h00000001);
        rc(8'h40, 32'h00000000);
    endtask
    task automatic t_stack;
        u_core.op(4'h8, 21'h012345, r);
        u_core.op(4'h4, 21'h01ABCD, r);
        rc(`RSC_OFF_CTRL, 32'h00000002);
        rc(`RSC_OFF_TOP_LO, 32'h000000CD);
        rc(`RSC_OFF_TOP_HI, 32'h000000AB);
        rc(`RSC_OFF_TOP_UP, 32'h00000001);
        u_core.op(4'h1, 21'h000000, r);
        `CHK(r.valid, 1'h0)
        rc(`RSC_OFF_CTRL, 32'h00000001);
        u_core.op(4'h2, 21'h000000, r);
        `CHK(r.addr, 21'h012345)
        rc(`RSC_OFF_CTRL, 32'h00000000);
    endtask
    task automatic t_underflow;
        wr(`RSC_OFF_IRQ_MSK, 32'h00000002);
        wr(`RSC_OFF_CFG, 32'h00000000);
        u_core.op(4'h2, 21'h000000, r);
        `CHK(r.underflow, 1'h1)
        `CHK(r.addr, 21'h000000)
        `CHK(device_reset_req, 1'h0)
        rc(`RSC_OFF_CTRL, 32'h00000040);
        rc(`RSC_OFF_CFG, 32'h00000000);
        `CHK(irq, 1'h1)
        rc(`RSC_OFF_IRQ_STS, 32'h00000002);
        `CHK(irq, 1'h0)
        wr(`RSC_OFF_CTRL, 32'h000000FF);
        rc(`RSC_OFF_CTRL, 32'h0000005F);
        wr(`RSC_OFF_CTRL, 32'h00000000);
        rc(`RSC_OFF_CTRL, 32'h00000000);
    endtask
    task automatic t_top_write;
        wr(`RSC_OFF_CTRL, 32'h00000005);
        wr(`RSC_OFF_TOP_LO, 32'h00000011);
        wr(`RSC_OFF_TOP_HI, 32'h00000022);
        wr(`RSC_OFF_TOP_UP, 32'h0000001F);
        u_core.op(4'h2, 21'h000000, r);
        `CHK(r.addr, 21'h1F2211)
        rc(`RSC_OFF_CTRL, 32'h00000004);
        wr(`RSC_OFF_CTRL, 32'h00000000);
    endtask
    // saturating overflow after thirty-one pushes
    task automatic t_saturate;
        for (pcv = 21'h000001; pcv <= 21'h00001F; pcv++) begin
            u_core.op(4'h4, pcv, r);
        end
        rc(`RSC_OFF_CTRL, 32'h0000009F);
        u_core.op(4'h4, 21'h000777, r);
        rc(`RSC_OFF_CTRL, 32'h0000009F);
        u_core.op(4'h2, 21'h000000, r);
        `CHK(r.addr, 21'h00001F)
        rc(`RSC_OFF_IRQ_STS, 32'h00000001);
        wr(`RSC_OFF_CTRL, 32'h00000000);
    endtask
    // overflow with the device reset enabled
    task automatic t_reset_ovf;
        wr(`RSC_OFF_CFG, 32'h00000001);
        wr(`RSC_OFF_IRQ_MSK, 32'h00000001);
        wr(`RSC_OFF_CTRL, 32'h0000001E);
        u_core.op(4'h4, 21'h000100, r);
        `CHK(device_reset_req, 1'h1)
        `CHK(irq, 1'h1)
        rc(`RSC_OFF_CTRL, 32'h00000080);
        wr(`RSC_OFF_CTRL, 32'h0000009F);
        u_core.op(4'h2, 21'h000000, r);
        `CHK(r.addr, 21'h000102)
        rc(`RSC_OFF_IRQ_STS, 32'h00000001);
        `CHK(irq, 1'h0)
    endtask
    // power-on reset in mid-run clears pointer, flags and mask, and returns the configuration to its reset value of one
    task automatic t_por;
        wr(`RSC_OFF_CFG, 32'h00000000);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        rc(`RSC_OFF_CTRL, 32'h00000000);
        rc(`RSC_OFF_CFG, 32'h00000001);
        rc(`RSC_OFF_IRQ_MSK, 32'h00000000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        hresetn = 1'h0;
        hsel = 1'h1;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'h0;
        hwdata = 32'h00000000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        t_reset();
        t_stack();
        t_underflow();
        t_top_write();
        t_saturate();
        t_reset_ovf();
        t_por();
        print_verdict();
    end
endmodule

bind return_stack_pointer_control rstack_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .core_req(core_req), .core_resp(core_resp),
    .device_reset_req(device_reset_req));
`default_nettype wire
